// File: shared/gate_pkg.sv
package gate_pkg;

    // ==========================================================
    // table geometry
    localparam int SPEC_W      = 8;
    localparam int PHASE_W     = 10;
    localparam int ADDR_W      = SPEC_W + PHASE_W;
    localparam int DATA_W      = 4;
    localparam int SEL_W       = 2;
    localparam int PHASE_BINS  = 1024;
    localparam int TABLE_DEPTH = 262144;

    // ==========================================================
    // spectral point counter
    localparam logic [SPEC_W-1:0] SPEC_FIRST = 8'h00;
    localparam logic [SPEC_W-1:0] SPEC_LAST  = 8'hFF;

    // ==========================================================
    // reset values
    localparam logic [PHASE_W-1:0] PHASE_RST = 10'h000;
    localparam logic               GATE_RST  = 1'h0;

    // ==========================================================
    // transform size of the joined engines
    typedef enum logic [1:0] {
        FFT_SHORT = 2'b00,
        FFT_512   = 2'b01,
        FFT_1K    = 2'b10,
        FFT_2K    = 2'b11
    } fft_size_t;

    localparam fft_size_t SIZE_RST    = FFT_512;
    localparam logic      WRITTEN_RST = 1'h0;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } block_state_t;

endpackage : gate_pkg

// File: shared/gate_table_if.sv
`timescale 1ns/100ps
interface gate_table_if;
    import gate_pkg::*;

    logic                 wr_en;
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic [ADDR_W-1:0]    rd_addr;
    logic [DATA_W-1:0]    rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);

endinterface : gate_table_if

// File: verilog/gate_table_mem.sv
`timescale 1ns/100ps
module gate_table_mem
    import gate_pkg::*;
#(
    parameter int DEPTH = TABLE_DEPTH
) (
    // clock
    input wire logic    clock,
    // table port
    gate_table_if.mem   tbl
);
    import gate_pkg::*;

    // ==========================================================
    // storage, one word per spectral point and phase bin
    logic [DATA_W-1:0] mem_ff [0:DEPTH-1];

    always_ff @(posedge clock) begin
        if (tbl.wr_en) begin
            mem_ff[tbl.wr_addr] <= tbl.wr_data;
        end
    end

    assign tbl.rd_data = mem_ff[tbl.rd_addr];

endmodule : gate_table_mem

// File: verilog/pulsar_gate_generator.sv
`timescale 1ns/100ps
module pulsar_gate_generator
    import gate_pkg::*;
#(
    parameter int DEPTH = TABLE_DEPTH
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // configuration
    input  wire gate_pkg::fft_size_t    fft_size,
    input  wire logic [1:0]             engine_id,
    input  wire logic [1:0]             chan_sel,
    input  wire logic                   gate_enable,
    // transform block start and phase
    input  wire logic                   block_start,
    input  wire logic [9:0]             block_phase,
    // final butterfly stage output strobe
    input  wire logic                   point_valid,
    // table load from host
    input  wire logic                   load_valid,
    input  wire logic [17:0]            load_addr,
    input  wire logic [3:0]             load_data,
    output logic                        load_ready,
    // gate to cross multipliers
    output logic                        gate_valid,
    output logic                        gate_discard,
    output logic [7:0]                  gate_point,
    output logic                        block_busy,
    output logic                        table_written
);
    import gate_pkg::*;

    // ==========================================================
    // bit of the table word that serves this engine and channel
    function automatic logic [SEL_W-1:0] word_bit(input fft_size_t size,
                                                  input logic [1:0] eng,
                                                  input logic [1:0] chan);
        logic [SEL_W-1:0] sel;
        sel = chan;
        case (size)
            FFT_SHORT: sel = chan;
            FFT_512:   sel = chan;
            FFT_1K:    sel = {chan[0], eng[0]};
            FFT_2K:    sel = eng;
            default:   sel = chan;
        endcase
        return sel;
    endfunction : word_bit

    // ==========================================================
    // table
    gate_table_if tbl ();

    gate_table_mem #(
        .DEPTH (DEPTH)
    ) u_table (
        .clock (clock),
        .tbl   (tbl)
    );

    // ==========================================================
    // block sequencing
    block_state_t           state_ff;
    block_state_t           nxt_state;
    logic [PHASE_W-1:0]     phase_ff;
    logic [PHASE_W-1:0]     nxt_phase;
    fft_size_t              size_ff;
    fft_size_t              nxt_size;
    logic [SPEC_W-1:0]      spec_ff;
    logic [SPEC_W-1:0]      nxt_spec;
    logic [PHASE_W-1:0]     use_phase;
    logic [SPEC_W-1:0]      use_spec;
    fft_size_t              use_size;
    logic                   take_point;

    always_comb begin
        // a point in the start cycle is the first point of the new block
        use_phase  = block_start ? block_phase : phase_ff;
        use_spec   = block_start ? SPEC_FIRST : spec_ff;
        use_size   = block_start ? fft_size : size_ff;
        take_point = point_valid && (block_start || (state_ff == ST_RUN));
        nxt_state  = state_ff;
        nxt_phase  = phase_ff;
        nxt_size   = size_ff;
        nxt_spec   = spec_ff;
        if (block_start) begin
            nxt_state = ST_RUN;
            nxt_phase = block_phase;
            nxt_size  = fft_size;
            nxt_spec  = SPEC_FIRST;
        end
        if (take_point) begin
            nxt_spec = use_spec + 8'h01;
            if (use_spec == SPEC_LAST) begin
                nxt_state = ST_IDLE;
                nxt_spec  = SPEC_FIRST;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            phase_ff <= PHASE_RST;
            size_ff  <= SIZE_RST;
            spec_ff  <= SPEC_FIRST;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            size_ff  <= nxt_size;
            spec_ff  <= nxt_spec;
        end
    end

    // ==========================================================
    // lookup and table load
    logic                   nxt_gate_valid;
    logic                   nxt_gate_discard;
    logic [SPEC_W-1:0]      nxt_gate_point;
    logic                   nxt_written;
    logic                   gate_valid_ff;
    logic                   gate_discard_ff;
    logic [SPEC_W-1:0]      gate_point_ff;
    logic                   written_ff;
    logic [SEL_W-1:0]       sel;
    logic [DATA_W-1:0]      chan_gate;

    // loads only between blocks so a lookup never sees a half-written word
    assign load_ready  = (state_ff == ST_IDLE) && !block_start;
    assign tbl.wr_en   = load_valid && load_ready;
    assign tbl.wr_addr = load_addr;
    assign tbl.wr_data = load_data;
    assign tbl.rd_addr = {use_phase, use_spec};

    // ==========================================================
    // discard bit of every channel of the addressed word
    generate
        for (genvar c = 0; c < DATA_W; c++) begin : g_chan
            assign chan_gate[c] = gate_enable && tbl.rd_data[c];
        end
    endgenerate

    always_comb begin
        sel              = word_bit(use_size, engine_id, chan_sel);
        nxt_gate_valid   = take_point;
        nxt_gate_discard = take_point && chan_gate[sel];
        nxt_gate_point   = take_point ? use_spec : gate_point_ff;
        nxt_written      = written_ff || tbl.wr_en;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_valid_ff   <= GATE_RST;
            gate_discard_ff <= GATE_RST;
            gate_point_ff   <= SPEC_FIRST;
            written_ff      <= WRITTEN_RST;
        end else begin
            gate_valid_ff   <= nxt_gate_valid;
            gate_discard_ff <= nxt_gate_discard;
            gate_point_ff   <= nxt_gate_point;
            written_ff      <= nxt_written;
        end
    end

    assign gate_valid    = gate_valid_ff;
    assign gate_discard  = gate_discard_ff;
    assign gate_point    = gate_point_ff;
    assign block_busy    = (state_ff == ST_RUN);
    assign table_written = written_ff;

endmodule : pulsar_gate_generator

// File: verif/gate_props_properties.sv
`timescale 1ns/100ps
module gate_props (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // stream and load inputs
    input wire logic       block_start,
    input wire logic       point_valid,
    input wire logic       gate_enable,
    input wire logic       load_valid,
    // outputs
    input wire logic       load_ready,
    input wire logic       gate_valid,
    input wire logic       gate_discard,
    input wire logic       block_busy,
    input wire logic       table_written,
    input wire logic [7:0] gate_point
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire        take = point_valid && (block_start || block_busy);
    logic [7:0] next_pt_ff;
    // ==========================================================
    // index that the next taken point must carry
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            next_pt_ff <= 8'h00;
        end else if (block_start) begin
            next_pt_ff <= {7'h00, point_valid};
        end else if (take) begin
            next_pt_ff <= next_pt_ff + 8'h01;
        end
    end
    // ==========================================================
    // gate stream
    chk_gate_latency: assert property (take |=> gate_valid) else $error("gate missing");
    chk_idle_quiet: assert property (!take |=> !gate_valid) else $error("spurious gate");
    chk_first_point: assert property (take && block_start |=> gate_point == 8'h00) else $error("bad first");
    chk_point_step: assert property (take && !block_start |=> gate_point == $past(next_pt_ff))
        else $error("point order broken");
    chk_enable_off: assert property (take && !gate_enable |=> !gate_discard) else $error("gate not off");
    chk_block_end: assert property (take && !block_start && next_pt_ff == 8'hFF |=> !block_busy)
        else $error("block overran");
    // ==========================================================
    // table load
    chk_load_refused: assert property (block_busy || block_start |-> !load_ready) else $error("load open");
    chk_written_set: assert property (load_valid && load_ready |=> table_written) else $error("no mark");
    chk_written_sticky: assert property (table_written |=> table_written) else $error("mark lost");
    cover property (take && block_start);
    cover property (take && gate_enable ##1 gate_discard);
    cover property (block_busy && load_valid);
endmodule : gate_props
bind pulsar_gate_generator gate_props u_gate_props (
    .clock         (clock),
    .rst_b         (rst_b),
    .block_start   (block_start),
    .point_valid   (point_valid),
    .gate_enable   (gate_enable),
    .load_valid    (load_valid),
    .load_ready    (load_ready),
    .gate_valid    (gate_valid),
    .gate_discard  (gate_discard),
    .block_busy    (block_busy),
    .table_written (table_written),
    .gate_point    (gate_point)
);

// File: verif/fft_point_source.sv
`timescale 1ns/100ps
module fft_point_source (
    input  wire logic clock,
    input  wire logic go,
    input  wire logic slow,
    output logic      block_start,
    output logic      point_valid
);
    int n = 0;
    initial begin
        block_start = 1'b0;
        point_valid = 1'b0;
    end
    // final stage output: start with point 0, then points in frequency order
    always @(negedge clock) begin
        block_start <= go;
        point_valid <= 1'b0;
        if (go) begin
            point_valid <= 1'b1;
            n <= 255;
        end else if (n > 0 && !(slow && $urandom_range(1))) begin
            point_valid <= 1'b1;
            n <= n - 1;
        end
    end
endmodule : fft_point_source

// File: verif/pulsar_gate_generator_bench.sv
`timescale 1ns/100ps
module pulsar_gate_generator_bench;
    import gate_pkg::*;
    logic        clock = 0, rst_b = 0, go = 0, slow = 0, gate_enable = 0, load_valid = 0;
    logic        block_start, point_valid, load_ready, gate_valid, gate_discard, block_busy, table_written;
    fft_size_t   fft_size = FFT_512;
    logic [1:0]  engine_id = 0, chan_sel = 0;
    logic [9:0]  block_phase = 0, ph;
    logic [17:0] load_addr = 0;
    logic [3:0]  load_data = 0, mem[int];
    logic [7:0]  gate_point;
    logic [8:0]  q[$];
    int          n_fail = 0, num_checks = 0, k = 256, b;
    always #4 clock = ~clock;
    fft_point_source src (.clock(clock), .go(go), .slow(slow), .block_start(block_start), .point_valid(point_valid));
    pulsar_gate_generator dut (.clock(clock), .rst_b(rst_b), .fft_size(fft_size), .engine_id(engine_id),
        .chan_sel(chan_sel), .gate_enable(gate_enable), .block_start(block_start), .block_phase(block_phase),
        .point_valid(point_valid), .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data),
        .load_ready(load_ready), .gate_valid(gate_valid), .gate_discard(gate_discard), .gate_point(gate_point),
        .block_busy(block_busy), .table_written(table_written));
    // ==========================================================
    // reference model of the gate stream
    always @(posedge clock) begin
        if (block_start) begin
            k = 0;
            ph = block_phase;
        end
        if (point_valid && k < 256) begin
            case (fft_size)
                FFT_1K: b = {chan_sel[0], engine_id[0]};
                FFT_2K: b = engine_id;
                default: b = chan_sel;
            endcase
            q.push_back({mem[{ph, k[7:0]}][b] & gate_enable, k[7:0]});
            k++;
        end
    end
    always @(negedge clock) if (gate_valid === 1'b1) begin
        check_gate({gate_discard, gate_point}, q.size() ? q.pop_front() : 9'bx);
    end
    task automatic check_gate(input logic [8:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected gate at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_gate
    task automatic check_flag(input logic got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_flag
    task automatic load(input logic [17:0] a);
        @(negedge clock);
        load_valid = 1'b1;
        load_addr = a;
        load_data = 4'($urandom);
        while (load_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        mem[a] = load_data;
    endtask : load
    task automatic finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(17));
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        check_flag(table_written, 1'b0);
        for (int i = 0; i < 512; i++) load({10'h2A + 10'(i[8]), i[7:0]});
        @(negedge clock);
        load_valid = 1'b0;
        check_flag(table_written, 1'b1);
        for (int m = 0; m < 4; m++) begin
            fft_size = fft_size_t'(m);
            engine_id = 2'($urandom);
            chan_sel = 2'($urandom);
            gate_enable = m != 0;
            slow = m[0];
            block_phase = 10'h2A;
            go <= 1'b1;
            @(negedge clock);
            go <= 1'b0;
            repeat (40) @(negedge clock);
            check_flag(block_busy, 1'b1);
            load_valid = 1'b1;
            @(negedge clock);
            check_flag(load_ready, 1'b0);
            load_valid = 1'b0;
            if (m == 3) begin
                block_phase = 10'h2B;
                go <= 1'b1;
                @(negedge clock);
                go <= 1'b0;
            end
            for (int t = 0; t < 2000 && block_busy !== 1'b0; t++) @(negedge clock);
            check_flag(block_busy, 1'b0);
        end
        repeat (4) @(negedge clock);
        check_flag(q.size() == 0, 1'b1);
        finish_test;
    end
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
endmodule : pulsar_gate_generator_bench
